// *** logic/dcs_codec_dev.sv ***
// Dual codec end: serial master, register banks and gain tap controls
`timescale 1ns/100ps
`default_nettype none
module dcs_codec_dev #(
   parameter int SAMPLE_DIV = dcs_pkg::SAMPLE_BASE
) (
   input  wire logic                   sys_clk_i,
   input  wire logic                   reset_i,
   dcs_codec_serial_port_if.dev                    codec_serial_port,
   input  wire logic [1:0][15:0]       adc_sample_i,
   input  wire logic [1:0]             mod_bit_i,
   input  wire logic [1:0][15:0]       interp_i,
   output logic      [1:0][2:0]        out_gain_o,
   output logic      [1:0]             out_mute_o,
   output logic      [1:0]             high_ref_o,
   output logic      [1:0]             reference_out_enable_o,
   output logic      [1:0][5:0]        atap_gain_o,
   output logic      [1:0]             atap_connect_o,
   output logic      [1:0][15:0]       dac_word_o,
   output logic      [1:0]             dac_load_o,
   output logic      [1:0][15:0]       dtap_coef_o,
   output logic      [1:0][15:0]       dtap_sum_o
);
   import dcs_pkg::*;

   logic [7:0]       regs_r    [NBLK][NREG];
   logic [7:0]       regs_nxt  [NBLK][NREG];
   logic [31:0]      chain_r, chain_nxt;
   dcs_state_t       state_r, state_nxt;
   logic [5:0]       half_cnt_r, half_cnt_nxt;
   logic [5:0]       bit_r, bit_nxt;
   logic             sclk_r, sclk_nxt;
   logic             fs_r, fs_nxt;
   logic             sdo_r, sdo_nxt;
   logic [15:0]      smp_cnt_r, smp_cnt_nxt;
   logic [1:0]       rb_valid_r, rb_valid_nxt;
   logic [1:0][15:0] rb_word_r, rb_word_nxt;
   logic [1:0]       pend_hi_r, pend_hi_nxt;
   logic [1:0]       pend_lo_r, pend_lo_nxt;
   logic [1:0][15:0] dtap_r, dtap_nxt;
   logic [1:0][15:0] dac_r, dac_nxt;
   logic [1:0]       dac_load_r, dac_load_nxt;
   logic [1:0][15:0] sum_r, sum_nxt;
   logic [1:0][5:0]  atg_r, atg_nxt;
   logic [1:0]       atc_r, atc_nxt;
   logic [5:0]       half;
   logic [15:0]      smp_lim;
   logic             smp_evt;

   always_comb begin
      logic [15:0] w;
      logic [4:0]  cf;
      dcs_mode_t   m;
      w = 16'h0000;
      cf = 5'h00;
      m = DCS_MODE_CTRL;
      regs_nxt = regs_r;
      chain_nxt = chain_r;
      state_nxt = state_r;
      half_cnt_nxt = half_cnt_r;
      bit_nxt = bit_r;
      sclk_nxt = sclk_r;
      fs_nxt = fs_r;
      sdo_nxt = sdo_r;
      rb_valid_nxt = rb_valid_r;
      rb_word_nxt = rb_word_r;
      pend_hi_nxt = pend_hi_r;
      pend_lo_nxt = pend_lo_r;
      dtap_nxt = dtap_r;
      dac_nxt = dac_r;
      dac_load_nxt = 2'b00;
      // Both blocks run on block 0 clock settings; host keeps them equal
      half = dcs_half_f(regs_r[0][REG_CLK]);
      smp_lim = 16'(dcs_mcd_f(regs_r[0][REG_CLK]))
              * 16'(16'(SAMPLE_DIV) << (2'h3 - regs_r[0][REG_CLK][CK_SRATE_LSB +: 2]));
      smp_evt = (smp_cnt_r >= 16'(smp_lim - 16'h0001));
      smp_cnt_nxt = smp_evt ? 16'h0000 : 16'(smp_cnt_r + 16'h0001);
      unique case (state_r)
         DCS_IDLE: begin
            // A late sample event during a frame is dropped, not queued
            if (smp_evt) begin
               for (int b = 0; b < NBLK; b++) begin
                  m = dcs_mode_f(regs_r[b][REG_SMODE]);
                  if (rb_valid_r[b])
                     w = rb_word_r[b];
                  else if (m == DCS_MODE_MIXED)
                     w = {1'b0, adc_sample_i[b][15:1]};
                  else if (m == DCS_MODE_DATA)
                     w = adc_sample_i[b];
                  else
                     w = 16'h0000;
                  chain_nxt[16*b +: 16] = w;
               end
               rb_valid_nxt = 2'b00;
               sdo_nxt = chain_nxt[31];
               fs_nxt = 1'b1;
               bit_nxt = 6'h00;
               half_cnt_nxt = 6'h00;
               sclk_nxt = 1'b0;
               state_nxt = DCS_SHIFT;
            end
         end
         DCS_SHIFT: begin
            half_cnt_nxt = 6'(half_cnt_r + 6'h01);
            if (half_cnt_r >= 6'(half - 6'h01)) begin
               half_cnt_nxt = 6'h00;
               sclk_nxt = ~sclk_r;
               if (sclk_r) begin
                  // Falling edge: sample input, present next output bit
                  chain_nxt = {chain_r[30:0], codec_serial_port.sdi};
                  sdo_nxt = chain_r[30];
                  bit_nxt = 6'(bit_r + 6'h01);
                  fs_nxt = (bit_r == WORD_LAST);
                  if (bit_r == LAST_BIT) begin
                     state_nxt = DCS_IDLE;
                     fs_nxt = 1'b0;
                     sdo_nxt = 1'b0;
                     for (int b = 0; b < NBLK; b++) begin
                        w = chain_nxt[16*b +: 16];
                        m = dcs_mode_f(regs_r[b][REG_SMODE]);
                        if (m == DCS_MODE_DATA) begin
                           dac_nxt[b] = w;
                           dac_load_nxt[b] = 1'b1;
                        end else if (m == DCS_MODE_MIXED && !w[CW_CTRL_BIT]) begin
                           dac_nxt[b] = {w[14:0], 1'b0};
                           dac_load_nxt[b] = 1'b1;
                        end else if (w[CW_CTRL_BIT]
                                     && w[CW_DEV_LSB +: 3] == 3'h0) begin
                           if (w[CW_RW_BIT]) begin
                              rb_valid_nxt[b] = 1'b1;
                              rb_word_nxt[b] = {w[15:8], regs_r[b][w[CW_REG_LSB +: 3]]};
                           end else begin
                              regs_nxt[b][w[CW_REG_LSB +: 3]] = w[7:0];
                              // Rate change restarts sample timing, no frame at once
                              if (b == 0 && w[CW_REG_LSB +: 3] == REG_CLK)
                                 smp_cnt_nxt = 16'h0000;
                              if (w[CW_REG_LSB +: 3] == REG_DT_HI)
                                 pend_hi_nxt[b] = 1'b1;
                              if (w[CW_REG_LSB +: 3] == REG_DT_LO)
                                 pend_lo_nxt[b] = 1'b1;
                              if (pend_hi_nxt[b] && pend_lo_nxt[b]) begin
                                 dtap_nxt[b] = {regs_nxt[b][REG_DT_HI],
                                                regs_nxt[b][REG_DT_LO]};
                                 pend_hi_nxt[b] = 1'b0;
                                 pend_lo_nxt[b] = 1'b0;
                              end
                           end
                        end
                     end
                  end
               end
            end
         end
      endcase
      for (int b = 0; b < NBLK; b++) begin
         sum_nxt[b] = mod_bit_i[b] ? 16'(interp_i[b] + dtap_r[b])
                                   : 16'(interp_i[b] - dtap_r[b]);
         cf = regs_r[b][REG_ATAP][AT_COEF_LSB +: 5];
         if (!regs_r[b][REG_PWR][PW_ATAP_BIT] || regs_r[b][REG_ATAP][AT_MUTE_BIT])
            atg_nxt[b] = 6'h00;
         else if (!cf[4])
            atg_nxt[b] = 6'(6'h10 - {1'b0, cf});
         else
            atg_nxt[b] = 6'(6'h0F - {1'b0, cf});
         atc_nxt[b] = regs_r[b][REG_PWR][PW_ATAP_BIT]
                    & regs_r[b][REG_ATAP][AT_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (int b = 0; b < NBLK; b++) begin
            for (int r = 0; r < NREG; r++) begin
               regs_r[b][r] <= REG_RESET;
            end
         end
         chain_r <= 32'h0000_0000;
         state_r <= DCS_IDLE;
         half_cnt_r <= 6'h00;
         bit_r <= 6'h00;
         sclk_r <= 1'b0;
         fs_r <= 1'b0;
         sdo_r <= 1'b0;
         smp_cnt_r <= 16'h0000;
         rb_valid_r <= 2'b00;
         rb_word_r <= '0;
         pend_hi_r <= 2'b00;
         pend_lo_r <= 2'b00;
         dtap_r <= '0;
         dac_r <= '0;
         dac_load_r <= 2'b00;
         sum_r <= '0;
         atg_r <= '0;
         atc_r <= 2'b00;
      end else begin
         regs_r <= regs_nxt;
         chain_r <= chain_nxt;
         state_r <= state_nxt;
         half_cnt_r <= half_cnt_nxt;
         bit_r <= bit_nxt;
         sclk_r <= sclk_nxt;
         fs_r <= fs_nxt;
         sdo_r <= sdo_nxt;
         smp_cnt_r <= smp_cnt_nxt;
         rb_valid_r <= rb_valid_nxt;
         rb_word_r <= rb_word_nxt;
         pend_hi_r <= pend_hi_nxt;
         pend_lo_r <= pend_lo_nxt;
         dtap_r <= dtap_nxt;
         dac_r <= dac_nxt;
         dac_load_r <= dac_load_nxt;
         sum_r <= sum_nxt;
         atg_r <= atg_nxt;
         atc_r <= atc_nxt;
      end
   end

   assign codec_serial_port.sclk = sclk_r;
   assign codec_serial_port.fs = fs_r;
   assign codec_serial_port.sdo = sdo_r;

   always_comb begin
      for (int b = 0; b < NBLK; b++) begin
         out_gain_o[b] = regs_r[b][REG_OUT][OUT_GAIN_LSB +: 3];
         out_mute_o[b] = regs_r[b][REG_OUT][OUT_MUTE_BIT];
         high_ref_o[b] = regs_r[b][REG_PWR][PW_HREF_BIT];
         reference_out_enable_o[b] = regs_r[b][REG_PWR][PW_BUFFERED_REFERENCE_PIN_BIT];
      end
   end

   assign atap_gain_o = atg_r;
   assign atap_connect_o = atc_r;
   assign dac_word_o = dac_r;
   assign dac_load_o = dac_load_r;
   assign dtap_coef_o = dtap_r;
   assign dtap_sum_o = sum_r;
endmodule
`default_nettype wire

// *** shared/dcs_pkg.sv ***
// Shared constants, types and decode helpers of the dual codec serial port
package dcs_pkg;
   localparam int NBLK    = 2;
   localparam int NREG    = 8;
   localparam int WORD_W  = 16;
   localparam int CHAIN_W = 32;

   // Control register indices
   localparam logic [2:0] REG_SMODE = 3'h0;  // serial_mode_control
   localparam logic [2:0] REG_CLK   = 3'h1;  // clock_rate_control
   localparam logic [2:0] REG_PWR   = 3'h2;  // power_reference_control
   localparam logic [2:0] REG_OUT   = 3'h3;  // output_gain_mute_control
   localparam logic [2:0] REG_E     = 3'h4;
   localparam logic [2:0] REG_ATAP  = 3'h5;  // analog_tap_control
   localparam logic [2:0] REG_DT_HI = 3'h6;  // digital_tap_upper
   localparam logic [2:0] REG_DT_LO = 3'h7;  // digital_tap_lower
   localparam logic [7:0] REG_RESET = 8'h00;

   // Field positions
   localparam int SM_DATA_BIT   = 0;
   localparam int SM_MIXED_BIT  = 1;
   localparam int CK_SRATE_LSB  = 0;
   localparam int CK_SDIV_LSB   = 2;
   localparam int CK_MCD_LSB    = 4;
   localparam int PW_ATAP_BIT   = 1;
   localparam int PW_BUFFERED_REFERENCE_PIN_BIT = 6;
   localparam int PW_HREF_BIT   = 7;
   localparam int OUT_GAIN_LSB  = 4;
   localparam int OUT_MUTE_BIT  = 7;
   localparam int AT_COEF_LSB   = 0;
   localparam int AT_EN_BIT     = 5;
   localparam int AT_MUTE_BIT   = 7;
   localparam int CW_CTRL_BIT   = 15;
   localparam int CW_RW_BIT     = 14;
   localparam int CW_DEV_LSB    = 11;
   localparam int CW_REG_LSB    = 8;

   // Timing: shortest sclk half period in system cycles
   localparam logic [5:0] MIN_HALF    = 6'h02;
   localparam int         SAMPLE_BASE = 256;
   localparam logic [5:0] LAST_BIT    = 6'h1F;
   localparam logic [5:0] WORD_LAST   = 6'h0F;

   typedef enum logic [1:0] {
      DCS_MODE_CTRL  = 2'b00,
      DCS_MODE_DATA  = 2'b01,
      DCS_MODE_MIXED = 2'b11
   } dcs_mode_t;

   typedef enum logic {
      DCS_IDLE  = 1'b0,
      DCS_SHIFT = 1'b1
   } dcs_state_t;

   function automatic dcs_mode_t dcs_mode_f(input logic [7:0] r);
      if (!r[SM_DATA_BIT])
         return DCS_MODE_CTRL;
      else if (r[SM_MIXED_BIT])
         return DCS_MODE_MIXED;
      else
         return DCS_MODE_DATA;
   endfunction

   // Master clock divider: codes 5 to 7 fall back to divide by one
   function automatic logic [2:0] dcs_mcd_f(input logic [7:0] r);
      logic [2:0] c;
      c = r[CK_MCD_LSB +: 3];
      if (c <= 3'h4)
         return 3'(c + 3'h1);
      else
         return 3'h1;
   endfunction

   // Sclk half period in system cycles; clamped since sys_clk is the fastest edge
   function automatic logic [5:0] dcs_half_f(input logic [7:0] r);
      logic [5:0] prod;
      prod = 6'(dcs_mcd_f(r)) * 6'(4'h8 >> r[CK_SDIV_LSB +: 2]);
      if ((prod >> 1) < MIN_HALF)
         return MIN_HALF;
      else
         return 6'(prod >> 1);
   endfunction
endpackage

// *** shared/dcs_codec_serial_port_if.sv ***
// Serial link between the dual codec and its host
`timescale 1ns/100ps
`default_nettype none
interface dcs_codec_serial_port_if;
   logic sclk;
   logic fs;
   logic sdo;
   logic sdi;
   modport dev  (output sclk, output fs, output sdo, input sdi);
   modport host (input sclk, input fs, input sdo, output sdi);
endinterface
`default_nettype wire

// *** logic/dcs_host_port.sv ***
// Host end of the codec link: follows the codec's frames, sends queued words
`timescale 1ns/100ps
`default_nettype none
module dcs_host_port (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   dcs_codec_serial_port_if.host             codec_serial_port,
   input  wire logic [1:0][15:0] tx_word_i,
   input  wire logic             tx_load_i,
   output logic                  tx_pending_o,
   output logic      [1:0][15:0] rx_word_o,
   output logic                  rx_valid_o
);
   import dcs_pkg::*;

   logic             sclk_d_r;
   logic             active_r, active_nxt;
   logic [5:0]       cnt_r, cnt_nxt;
   logic [31:0]      tx_r, tx_nxt;
   logic [31:0]      rx_r, rx_nxt;
   logic             pend_r, pend_nxt;
   logic [1:0][15:0] pend_w_r, pend_w_nxt;
   logic             sdi_r, sdi_nxt;
   logic [1:0][15:0] rxw_r, rxw_nxt;
   logic             rxv_r, rxv_nxt;

   always_comb begin
      logic [31:0] src;
      logic        rise;
      src = tx_r;
      rise = codec_serial_port.sclk & ~sclk_d_r;
      active_nxt = active_r;
      cnt_nxt = cnt_r;
      tx_nxt = tx_r;
      rx_nxt = rx_r;
      pend_nxt = pend_r;
      pend_w_nxt = pend_w_r;
      sdi_nxt = sdi_r;
      rxw_nxt = rxw_r;
      rxv_nxt = 1'b0;
      // Never drives a frame itself; only answers the codec's clock
      if (rise && (active_r || codec_serial_port.fs)) begin
         if (!active_r) begin
            // Words load only once the codec has begun its output word
            src = pend_r ? {pend_w_r[1], pend_w_r[0]} : 32'h0000_0000;
            pend_nxt = 1'b0;
            cnt_nxt = 6'h00;
            active_nxt = 1'b1;
         end else begin
            cnt_nxt = 6'(cnt_r + 6'h01);
         end
         sdi_nxt = src[31];
         tx_nxt = {src[30:0], 1'b0};
         rx_nxt = {rx_r[30:0], codec_serial_port.sdo};
         if (active_r && cnt_r == 6'(LAST_BIT - 6'h01)) begin
            active_nxt = 1'b0;
            rxw_nxt = {rx_nxt[31:16], rx_nxt[15:0]};
            rxv_nxt = 1'b1;
         end
      end
      // A new load in the consuming cycle wins and waits for the next frame
      if (tx_load_i) begin
         pend_nxt = 1'b1;
         pend_w_nxt = tx_word_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sclk_d_r <= 1'b0;
         active_r <= 1'b0;
         cnt_r <= 6'h00;
         tx_r <= 32'h0000_0000;
         rx_r <= 32'h0000_0000;
         pend_r <= 1'b0;
         pend_w_r <= '0;
         sdi_r <= 1'b0;
         rxw_r <= '0;
         rxv_r <= 1'b0;
      end else begin
         sclk_d_r <= codec_serial_port.sclk;
         active_r <= active_nxt;
         cnt_r <= cnt_nxt;
         tx_r <= tx_nxt;
         rx_r <= rx_nxt;
         pend_r <= pend_nxt;
         pend_w_r <= pend_w_nxt;
         sdi_r <= sdi_nxt;
         rxw_r <= rxw_nxt;
         rxv_r <= rxv_nxt;
      end
   end

   assign codec_serial_port.sdi = sdi_r;
   assign tx_pending_o = pend_r;
   assign rx_word_o = rxw_r;
   assign rx_valid_o = rxv_r;
endmodule
`default_nettype wire

// *** tb/dcs_link_asserts.sv ***
// Protocol checker for the serial link between the codec end and the host end
`timescale 1ns/100ps
`default_nettype none
module dcs_link_asserts (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic sclk,
   input  wire logic fs,
   input  wire logic sdo,
   input  wire logic sdi
);
   logic       act_r;
   logic       act_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic       sclk_d_r;
   logic       fs_d_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // Edges taken from delayed copies, since sampled functions stay out of comb logic
   always_comb begin
      act_nxt = act_r;
      cnt_nxt = cnt_r;
      if (fs && !fs_d_r && !act_r) begin
         act_nxt = 1'b1;
         cnt_nxt = 5'h00;
      end else if (act_r && sclk_d_r && !sclk) begin
         cnt_nxt = cnt_r + 5'h01;
         if (cnt_r == 5'h1F) begin
            act_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         act_r    <= 1'b0;
         cnt_r    <= 5'h00;
         sclk_d_r <= 1'b0;
         fs_d_r   <= 1'b0;
      end else begin
         act_r    <= act_nxt;
         cnt_r    <= cnt_nxt;
         sclk_d_r <= sclk;
         fs_d_r   <= fs;
      end
   end

   sequence s_frame_start;
      $rose(fs) && !act_r;
   endsequence

   sequence s_last_fall;
      $fell(sclk) && act_r && cnt_r == 5'h1F;
   endsequence

   a_sclk_in_frame: assert property ($rose(sclk) |-> act_r)
      else $error("serial clock rose outside a frame");
   a_frame_start_low: assert property (s_frame_start |-> !sclk ##1 (fs && !sclk))
      else $error("frame did not open with clock low and sync high");
   a_fs_mid_word: assert property ($rose(fs) && act_r |-> $fell(sclk) && cnt_r == 5'h0F)
      else $error("second word sync not at sixteenth fall");
   a_fs_drop_fall: assert property ($fell(fs) |-> $fell(sclk))
      else $error("frame sync dropped away from a clock fall");
   a_frame_end: assert property (s_last_fall |-> !fs && !sdo ##1 (!sclk && !sdo) [*8])
      else $error("link not idle after last bit");
   a_sclk_high_hold: assert property ($rose(sclk) |-> sclk [*2])
      else $error("serial clock high phase too short");
   a_sclk_low_hold: assert property ($fell(sclk) |-> !sclk [*2])
      else $error("serial clock low phase too short");
   a_sdo_on_fall: assert property ($changed(sdo) |-> $fell(sclk) || $rose(fs))
      else $error("codec output changed off a clock fall");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Bench joining codec end and host end, checked against a behavioural model
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dcs_pkg::*;
   localparam int SDIV = 64;  // Short sample base keeps the run brief
   logic             sys_clk_i;
   logic             reset_i;
   logic [1:0][15:0] adc_sample_i, interp_i, tx_word_i, rx_word_o;
   logic [1:0][15:0] dac_word_o, dtap_coef_o, dtap_sum_o;
   logic [1:0][2:0]  out_gain_o;
   logic [1:0][5:0]  atap_gain_o;
   logic [1:0]       mod_bit_i, out_mute_o, high_ref_o, reference_out_enable_o;
   logic [1:0]       atap_connect_o, dac_load_o;
   logic             tx_load_i, tx_pending_o, rx_valid_o;
   logic [7:0]       rm [2][8] = '{default: 8'h00};
   logic [15:0]      rbw [2];
   logic             rbv [2] = '{1'b0, 1'b0};
   logic [15:0]      coef [2] = '{16'h0000, 16'h0000};
   logic [15:0]      dq [2][$];
   int               de [2] = '{-1, -1};
   int               hw [2] = '{0, 0};
   int               hi_cnt = 0;
   int               last_hi = 0;
   int               error_cnt = 0;
   int               checked = 0;
   int unsigned      seed_v;

   dcs_codec_serial_port_if dcs_codec_serial_port_if_i ();
   dcs_codec_dev #(.SAMPLE_DIV(SDIV)) dcs_codec_dev_i (.sys_clk_i, .reset_i,
      .codec_serial_port(dcs_codec_serial_port_if_i), .adc_sample_i, .mod_bit_i, .interp_i, .out_gain_o, .out_mute_o,
      .high_ref_o, .reference_out_enable_o, .atap_gain_o, .atap_connect_o, .dac_word_o,
      .dac_load_o, .dtap_coef_o, .dtap_sum_o);
   dcs_host_port dcs_host_port_i (.sys_clk_i, .reset_i, .codec_serial_port(dcs_codec_serial_port_if_i), .tx_word_i,
      .tx_load_i, .tx_pending_o, .rx_word_o, .rx_valid_o);
   dcs_link_asserts dcs_link_asserts_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .sclk(dcs_codec_serial_port_if_i.sclk), .fs(dcs_codec_serial_port_if_i.fs), .sdo(dcs_codec_serial_port_if_i.sdo),
      .sdi(dcs_codec_serial_port_if_i.sdi));

   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // Collect every DAC load pulse and the length of the latest clock high phase
   always @(posedge sys_clk_i) begin
      for (int b = 0; b < 2; b++) begin
         if (dac_load_o[b] === 1'b1) dq[b].push_back(dac_word_o[b]);
      end
      if (dcs_codec_serial_port_if_i.sclk === 1'b1) begin
         hi_cnt++;
      end else if (hi_cnt != 0) begin
         last_hi = hi_cnt;
         hi_cnt = 0;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic [15:0] cw(input logic rd, input logic [2:0] r, input logic [7:0] d);
      return {1'b1, rd, 3'h0, r, d};
   endfunction

   function automatic int hexp(input logic [7:0] r);
      int mcd;
      int h;
      mcd = (r[6:4] <= 3'h4) ? int'(r[6:4]) + 1 : 1;
      h = mcd * (8 >> r[3:2]) / 2;
      return (h < 2) ? 2 : h;
   endfunction

   // Word that a block will shift out at the next frame; a pending read wins
   function automatic logic [15:0] mout(input int b);
      logic [1:0] m;
      m = rm[0][0][1:0];
      if (rbv[b]) begin
         rbv[b] = 1'b0;
         return {rbw[b][15:8], rm[b][rbw[b][10:8]]};
      end
      if (!m[0]) return 16'h0000;
      return m[1] ? {1'b0, adc_sample_i[b][15:1]} : adc_sample_i[b];
   endfunction

   task automatic apply(input int b, input logic [15:0] w, input logic [1:0] m);
      if (m[0] && !(m[1] && w[15])) begin
         de[b] = m[1] ? {w[14:0], 1'b0} : w;
      end else if (w[15] && w[13:11] == 3'h0) begin
         if (w[14]) begin
            rbv[b] = 1'b1;
            rbw[b] = w;
         end else begin
            rm[b][w[10:8]] = w[7:0];
            if (w[10:9] == 2'h3) hw[b] |= w[8] ? 2 : 1;
            if (hw[b] == 3) begin
               coef[b] = {rm[b][6], rm[b][7]};
               hw[b] = 0;
            end
         end
      end
   endtask

   task automatic chk_outs;
      int code;
      logic [5:0] g;
      for (int b = 0; b < 2; b++) begin
         code = int'(rm[b][5][4:0]);
         g = 6'(code < 16 ? 16 - code : 15 - code);
         if (!rm[b][2][1] || rm[b][5][7]) g = 6'h00;
         chk(16'(out_gain_o[b]), 16'(rm[b][3][6:4]));
         chk(16'(out_mute_o[b]), 16'(rm[b][3][7]));
         chk(16'(high_ref_o[b]), 16'(rm[b][2][7]));
         chk(16'(reference_out_enable_o[b]), 16'(rm[b][2][6]));
         chk(16'(atap_gain_o[b]), 16'(g));
         chk(16'(atap_connect_o[b]), 16'(rm[b][2][1] & rm[b][5][5]));
         chk(dtap_coef_o[b], coef[b]);
         chk(16'(dq[b].size()), 16'(de[b] >= 0));
         if (de[b] >= 0 && dq[b].size() > 0) chk(dq[b][0], 16'(de[b]));
         dq[b].delete();
         de[b] = -1;
      end
   endtask

   // One frame: load a word pair, catch the returned pair, then follow the applied words
   task automatic xfer(input logic [15:0] w2, input logic [15:0] w1);
      logic [15:0] e2;
      logic [15:0] e1;
      logic [1:0]  m;
      int          n;
      int          h;
      m = rm[0][0][1:0];
      h = hexp(rm[0][1]);
      // Predict only after the previous call's sample update has landed
      @(posedge sys_clk_i);
      e2 = mout(1);
      e1 = mout(0);
      tx_word_i <= {w2, w1};
      tx_load_i <= 1'b1;
      @(posedge sys_clk_i);
      tx_load_i <= 1'b0;
      #1;
      chk(16'(tx_pending_o), 16'h0001);
      n = 0;
      while (rx_valid_o !== 1'b1 && n < 4000) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk(16'(n < 4000), 16'h0001);
      chk(rx_word_o[1], e2);
      chk(rx_word_o[0], e1);
      chk(16'(tx_pending_o), 16'h0000);
      repeat (20) @(posedge sys_clk_i);
      chk(16'(last_hi), 16'(h));
      apply(1, w2, m);
      apply(0, w1, m);
      chk_outs();
      adc_sample_i <= {16'($urandom), 16'($urandom)};
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk_i);
      error_cnt++;
      test_done();
   end

   initial begin
      logic [2:0] regs [3];
      logic [4:0] codes [4];
      logic [7:0] clks [2];
      regs = '{REG_PWR, REG_OUT, REG_ATAP};
      codes = '{5'h00, 5'h0F, 5'h10, 5'h1F};
      clks = '{8'h0D, 8'h29};
      seed_v = $urandom(32'hBA17);
      reset_i = 1'b1;
      tx_word_i = '0;
      tx_load_i = 1'b0;
      mod_bit_i = 2'b00;
      interp_i = '0;
      adc_sample_i = {16'($urandom), 16'($urandom)};
      repeat (8) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(posedge sys_clk_i);
      chk_outs();
      for (int i = 0; i < 9; i++)
         xfer(cw(0, regs[i % 3], 8'($urandom)), cw(0, regs[i % 3], 8'($urandom)));
      xfer(cw(0, REG_PWR, 8'h02), cw(0, REG_PWR, 8'h02));
      foreach (codes[i]) xfer(cw(0, REG_ATAP, {3'h1, codes[i]}), cw(0, REG_ATAP, {3'h4, codes[i]}));
      xfer(cw(1, REG_ATAP, 8'h00), cw(1, REG_PWR, 8'h00));
      xfer(16'h0355, 16'h8B55);  // Flag clear, then a foreign device address: both dropped
      xfer(cw(0, REG_DT_HI, 8'h80), cw(0, REG_DT_LO, 8'($urandom)));
      xfer(cw(0, REG_DT_LO, 8'h00), cw(0, REG_DT_HI, 8'($urandom)));
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk_i);
         interp_i <= {16'($urandom), 16'($urandom)};
         mod_bit_i <= 2'(i);
         repeat (2) @(posedge sys_clk_i);
         #1;
         for (int b = 0; b < 2; b++)
            chk(dtap_sum_o[b], interp_i[b] + (mod_bit_i[b] ? coef[b] : -coef[b]));
      end
      foreach (clks[i]) begin
         xfer(cw(0, REG_CLK, clks[i]), cw(0, REG_CLK, clks[i]));
         xfer(16'h0000, 16'h0000);
      end
      // Mixed first: once in data mode every word is a sample and the mode is fixed
      xfer(cw(0, REG_SMODE, 8'h03), cw(0, REG_SMODE, 8'h03));
      for (int i = 0; i < 4; i++) xfer(16'($urandom) | 16'h0400, 16'($urandom) | 16'h0400);
      xfer(cw(0, REG_SMODE, 8'h01), cw(0, REG_SMODE, 8'h01));
      for (int i = 0; i < 3; i++) xfer(16'($urandom), 16'($urandom));
      test_done();
   end
endmodule
`default_nettype wire
